/* File: src/cdo_pkg.sv */
// package for the clear/call/decrement execution block
// assumes a single 10 MHz core clock and an axi4-lite register master
package cdo_pkg;

  // ****************************************
  // bus widths and responses
  // ****************************************
  localparam int CDO_ADDR_W = 8; // byte address width
  localparam int CDO_DATA_W = 32; // bus data width
  localparam logic [1:0] CDO_RESP_OKAY = 2'h0; // normal answer
  localparam logic [1:0] CDO_RESP_SLVERR = 2'h2; // unmapped or refused

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CDO_REG_ACC = 8'h00; // accumulator
  localparam logic [7:0] CDO_REG_STATUS = 8'h04; // status flags and page bits
  localparam logic [7:0] CDO_REG_PC = 8'h08; // program counter
  localparam logic [7:0] CDO_REG_OP = 8'h0c; // write issues one operation
  localparam logic [7:0] CDO_REG_WDOG = 8'h10; // watchdog counter and prescaler
  localparam logic [7:0] CDO_REG_STACK = 8'h14; // top of return stack
  localparam logic [7:0] CDO_REG_OPT = 8'h18; // prescaler assign, busy
  localparam logic [7:0] CDO_REG_FILE = 8'h80; // 32 file registers, one word each

  // ****************************************
  // field positions
  // ****************************************
  localparam int CDO_ST_ZERO = 2; // result-null flag
  localparam int CDO_ST_SLEEP = 3; // sleep_indicator, active low
  localparam int CDO_ST_EXPIRY = 4; // expiry_flag, active low
  localparam int CDO_ST_PAGE = 5; // page bits 6:5
  localparam int CDO_OPF_CODE = 0; // op code, 3 bits
  localparam int CDO_OPF_FILE = 4; // file index, 5 bits
  localparam int CDO_OPF_DEST = 9; // destination, 1 = file
  localparam int CDO_OPF_LIT = 16; // call literal, 8 bits
  localparam int CDO_OPT_PSA = 0; // prescaler belongs to watchdog
  localparam int CDO_OPT_BUSY = 8; // second instruction cycle in progress
  localparam int CDO_WD_PRE = 8; // prescaler field of watchdog word

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [7:0] CDO_ACC_RST = 8'h00; // accumulator after reset
  localparam logic [7:0] CDO_STATUS_RST = 8'h18; // both active-low flags high
  localparam logic [10:0] CDO_PC_RST = 11'h000; // program counter after reset
  localparam logic CDO_PSA_RST = 1'b1; // prescaler on watchdog
  localparam logic [7:0] CDO_PRE_MAX = 8'hff; // prescaler terminal count
  localparam logic [7:0] CDO_STATUS_MASK = 8'h7c; // implemented status bits

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    CDO_OP_NOP,
    CDO_OP_CLEAR_ACC,
    CDO_OP_CALL,
    CDO_OP_KICK_WDOG,
    CDO_OP_CLEAR_FILE,
    CDO_OP_INVERT_FILE,
    CDO_OP_DEC_FILE,
    CDO_OP_DEC_SKIP
  } cdo_op_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } cdo_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } cdo_axi_rsp_t;

endpackage

/* File: src/cdo_core.sv */
// execution unit for clear, call, watchdog kick, complement and decrement
// assumes an axi4-lite master on aclk; software issues operations by register
// How it works
// (RULE1) clear accumulator: zero into it, set zero flag
// (RULE2) call pushes program counter plus one
// (RULE3) call literal loads program counter bits 7:0
// (RULE4) call: page bits to pc 10:9, bit 8 cleared
// (RULE5) call takes two cycles, flags unchanged
// (RULE6) kick clears watchdog, prescaler only if assigned
// (RULE7) kick sets expiry and sleep flags to one
// (RULE8) clear file: zero into register, set zero flag
// (RULE9) invert file, result to accumulator or file
// (RULE10) decrement file, steered by dest, zero flag
// (RULE11) decrement-skip steers result, flags untouched
// (RULE12) zero result discards next, two cycles
// (RULE13) zero flag set exactly when result is zero
module cdo_core
  import cdo_pkg::*;
(
  input wire logic aclk, // core clock, 10 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire cdo_pkg::cdo_axi_req_t axi_req, // axi4-lite master signals
  output cdo_pkg::cdo_axi_rsp_t axi_rsp // axi4-lite slave signals
);
  import cdo_pkg::*;
  typedef enum logic [3:0] {
    CDO_SEL_ACC, CDO_SEL_STATUS, CDO_SEL_PC, CDO_SEL_OP, CDO_SEL_WDOG,
    CDO_SEL_STACK, CDO_SEL_OPT, CDO_SEL_FILE, CDO_SEL_NONE
  } cdo_sel_t;
  // address decode shared by read and write paths
  function automatic cdo_sel_t reg_sel(input logic [7:0] a);
    cdo_sel_t s;
    s = CDO_SEL_NONE;
    if (a[1:0] != 2'h0) s = CDO_SEL_NONE;
    else if (a >= CDO_REG_FILE) s = CDO_SEL_FILE;
    else if (a == CDO_REG_ACC) s = CDO_SEL_ACC;
    else if (a == CDO_REG_STATUS) s = CDO_SEL_STATUS;
    else if (a == CDO_REG_PC) s = CDO_SEL_PC;
    else if (a == CDO_REG_OP) s = CDO_SEL_OP;
    else if (a == CDO_REG_WDOG) s = CDO_SEL_WDOG;
    else if (a == CDO_REG_STACK) s = CDO_SEL_STACK;
    else if (a == CDO_REG_OPT) s = CDO_SEL_OPT;
    return s;
  endfunction
  // low byte merge under byte enable 0
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    return st[0] ? d[7:0] : old;
  endfunction
  // ****************************************
  // state
  // ****************************************
  logic [7:0] acc_q; // accumulator
  logic [7:0] status_q; // status, bits 6:2 kept
  logic [10:0] pc_q; // program counter
  logic [10:0] stack_q [2]; // return stack, entry 0 is top
  logic [7:0] file_q [32]; // file registers
  logic [7:0] wdog_q; // watchdog_counter
  logic [7:0] pre_q; // prescaler
  logic psa_q; // prescaler assigned to watchdog
  logic busy_q; // second cycle of call or skip
  logic [7:0] awaddr_q; // held write address
  logic aw_held_q; // write address taken
  logic [31:0] wdata_q; // held write data
  logic [3:0] wstrb_q; // held byte enables
  logic w_held_q; // write data taken
  logic bvalid_q; // write answer pending
  logic [1:0] bresp_q; // write answer code
  logic rvalid_q; // read answer pending
  logic [31:0] rdata_q; // read data
  logic [1:0] rresp_q; // read answer code
  // ****************************************
  // axi4-lite write path
  // ****************************************
  logic wr_go; // both halves held, perform write
  cdo_sel_t wsel; // write target
  logic exec; // operation accepted this cycle
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  assign wsel = reg_sel(awaddr_q);
  assign exec = wr_go && wsel == CDO_SEL_OP && !busy_q;
  // address and data channels taken independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (axi_req.awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (axi_req.wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end
  // write answer; unmapped or busy-refused operation gives slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= CDO_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wsel == CDO_SEL_NONE || (wsel == CDO_SEL_OP && busy_q)) ?
                 CDO_RESP_SLVERR : CDO_RESP_OKAY;
    end else if (axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // operation decode and result
  // ****************************************
  cdo_op_t op; // issued operation
  logic [4:0] fidx; // addressed file register
  logic dest; // 1 = back to file
  logic [7:0] fval; // file operand
  logic [7:0] res; // 8-bit result
  logic to_acc; // result goes to accumulator
  logic to_file; // result goes to file
  logic upd_z; // operation affects zero flag
  logic skip; // discard the prefetched instruction
  logic is_call; // subroutine call
  logic is_kick; // watchdog kick
  assign op = cdo_op_t'(wdata_q[CDO_OPF_CODE +: 3]);
  assign fidx = wdata_q[CDO_OPF_FILE +: 5];
  assign dest = wdata_q[CDO_OPF_DEST];
  assign fval = file_q[fidx];
  always_comb begin
    res = 8'h00;
    to_acc = 1'b0;
    to_file = 1'b0;
    upd_z = 1'b0;
    skip = 1'b0;
    is_call = 1'b0;
    is_kick = 1'b0;
    case (op)
      CDO_OP_CLEAR_ACC: begin // [RULE1]
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      CDO_OP_CLEAR_FILE: begin // [RULE8]
        to_file = 1'b1;
        upd_z = 1'b1;
      end
      CDO_OP_INVERT_FILE: begin // [RULE9]
        res = ~fval;
        to_acc = !dest;
        to_file = dest;
        upd_z = 1'b1;
      end
      CDO_OP_DEC_FILE: begin // [RULE10]
        res = fval - 8'h01;
        to_acc = !dest;
        to_file = dest;
        upd_z = 1'b1;
      end
      CDO_OP_DEC_SKIP: begin // [RULE11]
        res = fval - 8'h01;
        to_acc = !dest;
        to_file = dest;
        skip = (res == 8'h00); // [RULE12]
      end
      CDO_OP_CALL: is_call = 1'b1;
      CDO_OP_KICK_WDOG: is_kick = 1'b1;
      default: ;
    endcase
  end

  // ****************************************
  // accumulator and file registers
  // ****************************************
  // accumulator: operation result or bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) acc_q <= CDO_ACC_RST;
    else if (exec && to_acc) acc_q <= res; // [RULE9] [RULE10] [RULE11]
    else if (wr_go && wsel == CDO_SEL_ACC) acc_q <= merge8(acc_q, wdata_q, wstrb_q);
  end
  // one flop group per file register
  for (genvar i = 0; i < 32; i++) begin : g_file
    always_ff @(posedge aclk) begin
      if (!aresetn) file_q[i] <= 8'h00;
      else if (exec && to_file && fidx == 5'(i)) file_q[i] <= res; // [RULE8]
      else if (wr_go && wsel == CDO_SEL_FILE && awaddr_q[6:2] == 5'(i))
        file_q[i] <= merge8(file_q[i], wdata_q, wstrb_q);
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  logic wd_tick; // watchdog advance this cycle
  logic wd_wrap; // watchdog overflow
  assign wd_tick = psa_q ? (pre_q == CDO_PRE_MAX) : 1'b1;
  assign wd_wrap = wd_tick && wdog_q == 8'hff && !(exec && is_kick);
  // zero flag from result; kick sets both active-low flags; overflow clears expiry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= CDO_STATUS_RST;
    end else begin
      if (wr_go && wsel == CDO_SEL_STATUS)
        status_q <= merge8(status_q, wdata_q, wstrb_q) & CDO_STATUS_MASK;
      if (exec && upd_z) status_q[CDO_ST_ZERO] <= (res == 8'h00); // [RULE13] [RULE1]
      if (exec && is_kick) begin
        status_q[CDO_ST_EXPIRY] <= 1'b1; // [RULE7]
        status_q[CDO_ST_SLEEP] <= 1'b1; // [RULE7]
      end
      if (wd_wrap) status_q[CDO_ST_EXPIRY] <= 1'b0; // hardware event beats bus write
    end
  end

  // ****************************************
  // program counter, stack, two-cycle ops
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) pc_q <= CDO_PC_RST;
    else if (exec && is_call)
      pc_q <= {status_q[CDO_ST_PAGE +: 2], 1'b0, wdata_q[CDO_OPF_LIT +: 8]}; // [RULE3] [RULE4]
    else if (exec && skip) pc_q <= pc_q + 11'h002; // [RULE12]
    else if (exec) pc_q <= pc_q + 11'h001;
    else if (wr_go && wsel == CDO_SEL_PC) pc_q <= wdata_q[10:0];
  end
  // push return address; lower entry takes the old top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_q[0] <= 11'h000;
      stack_q[1] <= 11'h000;
    end else if (exec && is_call) begin
      stack_q[0] <= pc_q + 11'h001; // [RULE2]
      stack_q[1] <= stack_q[0];
    end
  end
  // second instruction cycle blocks the next operation
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_q <= 1'b0;
    else busy_q <= exec && (is_call || skip); // [RULE5] [RULE12]
  end

  // ****************************************
  // watchdog and prescaler
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_q <= 8'h00;
      pre_q <= 8'h00;
      psa_q <= CDO_PSA_RST;
    end else begin
      if (wr_go && wsel == CDO_SEL_OPT && wstrb_q[0]) psa_q <= wdata_q[CDO_OPT_PSA];
      if (exec && is_kick) begin
        wdog_q <= 8'h00; // [RULE6]
        if (psa_q) pre_q <= 8'h00; // [RULE6]
      end else begin
        if (psa_q) pre_q <= pre_q + 8'h01;
        if (wd_tick) wdog_q <= wdog_q + 8'h01;
      end
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  cdo_sel_t rsel; // read target
  logic [31:0] rmux; // read value
  assign rsel = reg_sel(axi_req.araddr);
  always_comb begin
    rmux = 32'h0000_0000;
    case (rsel)
      CDO_SEL_ACC: rmux = {24'h000000, acc_q};
      CDO_SEL_STATUS: rmux = {24'h000000, status_q};
      CDO_SEL_PC: rmux = {21'h000000, pc_q};
      CDO_SEL_WDOG: rmux = {16'h0000, pre_q, wdog_q};
      CDO_SEL_STACK: rmux = {21'h000000, stack_q[0]};
      CDO_SEL_OPT: rmux = {23'h000000, busy_q, 7'h00, psa_q};
      CDO_SEL_FILE: rmux = {24'h000000, file_q[axi_req.araddr[6:2]]};
      default: rmux = 32'h0000_0000;
    endcase
  end
  // read taken while no answer is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= CDO_RESP_OKAY;
    end else if (axi_req.arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rmux;
      rresp_q <= (rsel == CDO_SEL_NONE) ? CDO_RESP_SLVERR : CDO_RESP_OKAY;
    end else if (axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign axi_rsp.awready = !aw_held_q;
  assign axi_rsp.wready = !w_held_q;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.arready = !rvalid_q;
  assign axi_rsp.rvalid = rvalid_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_clear_acc;
    exec && op == CDO_OP_CLEAR_ACC |=> acc_q == 8'h00 && status_q[CDO_ST_ZERO];
  endproperty
  a_clear_acc: assert property (p_clear_acc) else $error("clear acc wrong"); // [RULE1]
  property p_push;
    exec && is_call |=> stack_q[0] == $past(pc_q) + 11'h001;
  endproperty
  a_push: assert property (p_push) else $error("bad return address"); // [RULE2]
  property p_call_low;
    exec && is_call |=> pc_q[7:0] == $past(wdata_q[23:16]);
  endproperty
  a_call_low: assert property (p_call_low) else $error("call low bits wrong"); // [RULE3]
  property p_call_page;
    exec && is_call |=> pc_q[10:9] == $past(status_q[6:5]) && !pc_q[8];
  endproperty
  a_call_page: assert property (p_call_page) else $error("call page wrong"); // [RULE4]
  property p_call_two;
    exec && is_call |=> busy_q && $stable(status_q) ##1 !busy_q;
  endproperty
  a_call_two: assert property (p_call_two) else $error("call timing wrong"); // [RULE5]
  // prescaler cleared only while it belongs to the watchdog, else left alone
  property p_kick;
    exec && is_kick |=> wdog_q == 8'h00 &&
      ($past(psa_q) ? pre_q == 8'h00 : pre_q == $past(pre_q));
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not clear"); // [RULE6]
  property p_kick_flags;
    exec && is_kick |=> status_q[CDO_ST_EXPIRY] && status_q[CDO_ST_SLEEP];
  endproperty
  a_kick_flags: assert property (p_kick_flags) else $error("kick flags wrong"); // [RULE7]
  property p_clear_file;
    exec && op == CDO_OP_CLEAR_FILE |=> file_q[$past(fidx)] == 8'h00 && status_q[CDO_ST_ZERO];
  endproperty
  a_clear_file: assert property (p_clear_file) else $error("clear file wrong"); // [RULE8]
  property p_invert;
    exec && op == CDO_OP_INVERT_FILE && !dest |=> acc_q == ~$past(fval);
  endproperty
  a_invert: assert property (p_invert) else $error("invert wrong"); // [RULE9]
  property p_dec;
    exec && op == CDO_OP_DEC_FILE && dest |=> file_q[$past(fidx)] == $past(fval) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong"); // [RULE10]
  property p_dec_skip_flags;
    exec && op == CDO_OP_DEC_SKIP |=> status_q[CDO_ST_ZERO] == $past(status_q[CDO_ST_ZERO]);
  endproperty
  a_dec_skip_flags: assert property (p_dec_skip_flags) else $error("skip hit zero flag"); // [RULE11]
  property p_skip;
    exec && skip |=> pc_q == $past(pc_q) + 11'h002 && busy_q ##1 !busy_q;
  endproperty
  a_skip: assert property (p_skip) else $error("skip wrong"); // [RULE12]
  property p_zero;
    exec && upd_z |=> status_q[CDO_ST_ZERO] == ($past(res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RULE13]
  c_call: cover property (exec && is_call ##2 exec);
  c_skip: cover property (exec && skip);
  c_kick: cover property (exec && is_kick && psa_q);
  c_refused: cover property (wr_go && wsel == CDO_SEL_OP && busy_q);

endmodule // cdo_core

/* File: verif/cdo_axi_master.sv */
// bus master model: stands in for software on the register bus
// assumes the design samples every channel on the rising edge of aclk
module cdo_axi_master
  import cdo_pkg::*;
(
  input wire logic aclk, // core clock
  output cdo_pkg::cdo_axi_req_t req, // master signals to the design
  input wire cdo_pkg::cdo_axi_rsp_t rsp // slave answers
);
  timeunit 1ns;
  timeprecision 1ns;

  initial req = '0; // idle bus from time zero

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) begin
        req.awvalid <= 1'b0;
        req.awaddr <= ~a; // released lines stop showing the old value
      end
      if (req.wvalid && rsp.wready) begin
        req.wvalid <= 1'b0;
        req.wdata <= ~d;
      end
      if (rsp.bvalid) begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk); // keeps release and next request in separate steps
  endtask

  // one read: held until taken, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) begin
        req.arvalid <= 1'b0;
        req.araddr <= ~a;
      end
      if (rsp.rvalid) begin
        d = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask
endmodule // cdo_axi_master

/* File: verif/tb_clear_call_decrement_ops.sv */
// self-checking bench for the clear/call/decrement execution block
// assumes cdo_core and the bus master model; one 10 MHz clock
module tb_clear_call_decrement_ops;
  timeunit 1ns;
  timeprecision 1ns;
  import cdo_pkg::*;

  // ****************************************
  // clock, reset, instances
  // ****************************************
  logic aclk; // core clock
  logic aresetn; // reset, active low
  cdo_axi_req_t req; // bus request
  cdo_axi_rsp_t rsp; // bus answer
  int bad_count = 0; // mismatches
  int checked = 0; // comparisons made

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  cdo_core dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp));
  cdo_axi_master mst_u (.aclk(aclk), .req(req), .rsp(rsp));

  // ****************************************
  // helpers
  // ****************************************
  // operation word: code, file index, destination, call literal
  function automatic logic [31:0] opw(input logic [2:0] c, input logic [4:0] f,
                                      input logic d, input logic [7:0] k);
    return {8'h00, k, 6'h00, d, f, 1'b0, c};
  endfunction

  // byte address of file register i
  function automatic logic [7:0] fa(input logic [4:0] i);
    return CDO_REG_FILE + {1'b0, i, 2'b00};
  endfunction

  task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s response expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    mst_u.wr(a, d, r);
    chk_resp("write", CDO_RESP_OKAY, r);
  endtask

  task automatic rreg(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    mst_u.rd(a, v, r);
    chk_resp(what, CDO_RESP_OKAY, r);
    chk_data(what, exp, v);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset values, unmapped and misaligned places
  task automatic t_reset_values();
    logic [31:0] v;
    logic [1:0] r;
    rreg("accumulator", CDO_REG_ACC, 32'h0);
    rreg("status", CDO_REG_STATUS, 32'h18);
    rreg("program counter", CDO_REG_PC, 32'h0);
    rreg("stack top", CDO_REG_STACK, 32'h0);
    rreg("option", CDO_REG_OPT, 32'h1);
    mst_u.rd(8'h1c, v, r);
    chk_resp("unmapped read", CDO_RESP_SLVERR, r);
    mst_u.wr(8'h02, 32'h0, r);
    chk_resp("misaligned write", CDO_RESP_SLVERR, r);
  endtask

  // clear accumulator from a nonzero value
  task automatic t_clear_acc();
    wreg(CDO_REG_ACC, 32'h5a);
    wreg(CDO_REG_OP, opw(CDO_OP_CLEAR_ACC, 5'h0, 1'b0, 8'h00));
    rreg("accumulator", CDO_REG_ACC, 32'h0);
    rreg("status", CDO_REG_STATUS, 32'h1c);
  endtask

  // two calls: literal extremes, page values 2 and 1, bit 8 set before the first
  task automatic t_call();
    wreg(CDO_REG_STATUS, 32'h58);
    wreg(CDO_REG_PC, 32'h1ff);
    wreg(CDO_REG_OP, opw(CDO_OP_CALL, 5'h0, 1'b0, 8'hff));
    rreg("stack top", CDO_REG_STACK, 32'h200);
    rreg("program counter", CDO_REG_PC, 32'h4ff);
    rreg("status", CDO_REG_STATUS, 32'h58);
    wreg(CDO_REG_STATUS, 32'h38);
    wreg(CDO_REG_PC, 32'h0ff);
    wreg(CDO_REG_OP, opw(CDO_OP_CALL, 5'h0, 1'b0, 8'h00));
    rreg("stack top", CDO_REG_STACK, 32'h100);
    rreg("program counter", CDO_REG_PC, 32'h200);
    rreg("status", CDO_REG_STATUS, 32'h38);
    wreg(CDO_REG_STATUS, 32'h18);
  endtask

  // watchdog kick with the prescaler on the watchdog, then on the timer
  task automatic t_kick();
    logic [31:0] v;
    logic [1:0] r;
    int n;
    logic [7:0] p; // prescaler just before the timer-side kick
    wreg(CDO_REG_STATUS, 32'h04);
    n = 0;
    v = 32'h0;
    while ((v[15:8] < 8'h28 || v[15:8] > 8'hc8) && n < 80) begin
      mst_u.rd(CDO_REG_WDOG, v, r);
      n++;
    end
    wreg(CDO_REG_OP, opw(CDO_OP_KICK_WDOG, 5'h0, 1'b0, 8'h00));
    mst_u.rd(CDO_REG_WDOG, v, r);
    chk_data("watchdog counter", 32'h0, {24'h0, v[7:0]});
    chk_data("prescaler cleared", 32'h1, {31'h0, v[15:8] < 8'h10});
    rreg("status", CDO_REG_STATUS, 32'h1c);
    wreg(CDO_REG_OPT, 32'h0);
    mst_u.rd(CDO_REG_WDOG, v, r);
    p = v[15:8];
    wreg(CDO_REG_OP, opw(CDO_OP_KICK_WDOG, 5'h0, 1'b0, 8'h00));
    mst_u.rd(CDO_REG_WDOG, v, r);
    chk_data("fast counter restarted", 32'h1, {31'h0, v[7:0] < 8'h10});
    chk_data("prescaler kept", {24'h0, p}, {24'h0, v[15:8]});
    wreg(CDO_REG_OPT, 32'h1);
    wreg(CDO_REG_OP, opw(CDO_OP_KICK_WDOG, 5'h0, 1'b0, 8'h00));
  endtask

  // clear the highest file register
  task automatic t_clear_file();
    wreg(fa(5'd31), 32'h77);
    wreg(CDO_REG_STATUS, 32'h18);
    wreg(CDO_REG_OP, opw(CDO_OP_CLEAR_FILE, 5'd31, 1'b0, 8'h00));
    rreg("file 31", fa(5'd31), 32'h0);
    rreg("status", CDO_REG_STATUS, 32'h1c);
  endtask

  // complement to each destination, zero flag both ways
  task automatic t_invert();
    wreg(fa(5'd3), 32'h0f);
    wreg(CDO_REG_OP, opw(CDO_OP_INVERT_FILE, 5'd3, 1'b0, 8'h00));
    rreg("accumulator", CDO_REG_ACC, 32'hf0);
    rreg("file 3", fa(5'd3), 32'h0f);
    rreg("status", CDO_REG_STATUS, 32'h18);
    wreg(fa(5'd4), 32'hff);
    wreg(CDO_REG_OP, opw(CDO_OP_INVERT_FILE, 5'd4, 1'b1, 8'h00));
    rreg("file 4", fa(5'd4), 32'h0);
    rreg("status", CDO_REG_STATUS, 32'h1c);
  endtask

  // decrement to zero into the file, and wrap from zero into the accumulator
  task automatic t_dec();
    wreg(fa(5'd5), 32'h01);
    wreg(CDO_REG_OP, opw(CDO_OP_DEC_FILE, 5'd5, 1'b1, 8'h00));
    rreg("file 5", fa(5'd5), 32'h0);
    rreg("status", CDO_REG_STATUS, 32'h1c);
    wreg(fa(5'd6), 32'h00);
    wreg(CDO_REG_OP, opw(CDO_OP_DEC_FILE, 5'd6, 1'b0, 8'h00));
    rreg("accumulator", CDO_REG_ACC, 32'hff);
    rreg("file 6", fa(5'd6), 32'h0);
    rreg("status", CDO_REG_STATUS, 32'h18);
  endtask

  // decrement-skip: nonzero result advances by one, zero result by two
  task automatic t_dec_skip();
    wreg(CDO_REG_PC, 32'h010);
    wreg(fa(5'd7), 32'h02);
    wreg(CDO_REG_STATUS, 32'h1c);
    wreg(CDO_REG_OP, opw(CDO_OP_DEC_SKIP, 5'd7, 1'b1, 8'h00));
    rreg("file 7", fa(5'd7), 32'h01);
    rreg("program counter", CDO_REG_PC, 32'h011);
    rreg("status", CDO_REG_STATUS, 32'h1c);
    wreg(CDO_REG_STATUS, 32'h18);
    wreg(CDO_REG_OP, opw(CDO_OP_DEC_SKIP, 5'd7, 1'b0, 8'h00));
    rreg("accumulator", CDO_REG_ACC, 32'h0);
    rreg("file 7", fa(5'd7), 32'h01);
    rreg("program counter", CDO_REG_PC, 32'h013);
    rreg("status", CDO_REG_STATUS, 32'h18);
  endtask

  // ****************************************
  // sequence, watchdog, verdict
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_clear_acc();
    t_call();
    t_kick();
    t_clear_file();
    t_invert();
    t_dec();
    t_dec_skip();
    end_of_test();
  end

  // about 250 cycles expected; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end
endmodule // tb_clear_call_decrement_ops
